// >>> rtl/ifbm_defs.svh
// Offsets, field positions, reset values and encodings of the fetch master.
// Assumes a 4-bit register address port with word-aligned byte offsets.
`ifndef IFBM_DEFS_SVH
`define IFBM_DEFS_SVH
// ==========================================
// Register map
`define IFBM_CFG_ADDR    4'h0
`define IFBM_STAT_ADDR   4'h4
// ==========================================
// Configuration fields
`define IFBM_CFG_NC_SIZE  0
`define IFBM_CFG_NO_ALLOC 1
`define IFBM_CFG_PRIO_LO 2
`define IFBM_CFG_RESET   4'h0
// ==========================================
// Status fields
`define IFBM_STAT_ERR    0
// ==========================================
// Transfer size encodings and beat counts
`define IFBM_SIZE_4W     2'h1
`define IFBM_SIZE_8W     2'h2
`define IFBM_BEATS_8W32  4'h8
`define IFBM_BEATS_8W64  4'h4
`define IFBM_BEATS_4W32  4'h4
`define IFBM_BEATS_4W64  4'h2
`endif

// >>> rtl/ifbm_fetch_master.sv
// Instruction fetch bus master with an eight-word fill buffer.
// Assumes the bus runs on mclk; slave inputs need no synchroniser.
//
// How it works
// - Only read requests leave this block; no write path exists.
// - Request address is 30 bits out, read data is 64 bits in.
// - Works with 32- or 64-bit slaves, one beat per cycle.
// - Cache miss or non-cacheable access raises a fetch request.
// - Requests are aligned words, so no byte enables are driven.
// - Size output encodes four or eight words; cacheable uses eight.
// - Cacheable, user attribute and priority go with each request.
// - A branch or interrupt can abort an outstanding request.
// - Beats come in any order; word position input places them.
// - Every beat fills the buffer; target word is forwarded at once.
// - Later fetches hit the fill buffer, even while the line arrives.
// - Non-cacheable size follows a software request-size bit.
// - Non-cacheable lines stay only in the buffer until replaced.
// - Full cacheable line goes to the cache unless no-allocate is set.
// - Touch-instruction lines go to the cache even with no-allocate set, unless a beat errored.
// - Buffer hits answer with the cache hit latency.
// - Request-size bit zero gives four words, one gives eight.
// - Abort only cancels a request not yet acknowledged.
// - All cycles count on one clock shared with the core.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ifbm_defs.svh"

module ifbm_fetch_master (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // Core side
  input  wire logic                 cpuReq,
  input  wire logic [29:0]          cpuAddr,
  input  wire logic                 cpuCacheable,
  input  wire logic                 cpuUserAttr,
  input  wire logic                 cpuTouch,
  input  wire logic                 cacheHit,
  input  wire logic                 abortReq,
  output logic                      instrValid,
  output logic [31:0]               instrData,
  output logic                      cacheWrEn,
  output logic [26:0]               cacheWrLine,
  output logic [255:0]              cacheWrData,
  // Register port
  input  wire logic [3:0]           regAddr,
  input  wire logic [31:0]          regWdata,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output logic [31:0]               regRdata,
  // Bus side
  output logic                      fetchReq,
  output logic [29:0]               fetchAddr,
  output logic [1:0]                fetchXferSize,
  output logic                      fetchCacheableAttr,
  output logic                      fetchUserAttr,
  output logic [1:0]                fetchPriority,
  output logic                      fetchAbort,
  input  wire logic                 slaveAddrAck,
  input  wire logic                 slaveWidth64,
  input  wire logic                 slaveRdDataAck,
  input  wire logic [63:0]          slaveRdData,
  input  wire logic [2:0]           slaveRdWordPos,
  input  wire logic                 slaveError
);
  import ifbm_pkg::*;

  ifbm_regs_t r_reg;
  ifbm_regs_t r_next;
  logic       bufHit;
  logic       beatHasTarget;
  logic       fwd;
  logic       done;
  logic       missStart;
  logic [3:0] need;
  logic [2:0] evenPos;

  // ==========================================
  // Combinational helpers
  always_comb
  begin
    bufHit = r_reg.lineOk && cpuAddr[29:3] == r_reg.addr[29:3]
             && r_reg.vld[cpuAddr[2:0]];
    evenPos = {slaveRdWordPos[2:1], 1'b0};
    if (r_reg.size8)
    begin
      need = r_reg.w64 ? `IFBM_BEATS_8W64 : `IFBM_BEATS_8W32;
    end
    else
    begin
      need = r_reg.w64 ? `IFBM_BEATS_4W64 : `IFBM_BEATS_4W32;
    end
    if (r_reg.w64)
    begin
      beatHasTarget = slaveRdWordPos[2:1] == r_reg.addr[2:1];
    end
    else
    begin
      beatHasTarget = slaveRdWordPos == r_reg.addr[2:0];
    end
    fwd = r_reg.st == ST_DATA && slaveRdDataAck && r_reg.want
          && beatHasTarget;
    done = r_reg.st == ST_DATA && slaveRdDataAck
           && r_reg.beats + 4'h1 == need;
    missStart = r_reg.st == ST_IDLE && cpuReq && !bufHit
                && (cpuTouch || !cacheHit || !cpuCacheable);
  end

  // ==========================================
  // Next state
  always_comb
  begin
    r_next = r_reg;
    r_next.instrValid = 1'b0;
    r_next.cacheWr = 1'b0;
    r_next.rdata = 32'h0000_0000;
    // Register port
    if (regWr)
    begin
      if (regAddr == `IFBM_CFG_ADDR)
      begin
        r_next.ncSize = regWdata[`IFBM_CFG_NC_SIZE];
        r_next.noAlloc = regWdata[`IFBM_CFG_NO_ALLOC];
        r_next.cfgPrio = regWdata[`IFBM_CFG_PRIO_LO +: 2];
      end
      else if (regAddr == `IFBM_STAT_ADDR)
      begin
        if (regWdata[`IFBM_STAT_ERR])
        begin
          r_next.err = 1'b0;
        end
      end
    end
    if (regRd)
    begin
      if (regAddr == `IFBM_CFG_ADDR)
      begin
        r_next.rdata = {28'h000_0000, r_reg.cfgPrio, r_reg.noAlloc, r_reg.ncSize};
      end
      else if (regAddr == `IFBM_STAT_ADDR)
      begin
        r_next.rdata = {16'h0000, r_reg.vld, r_reg.beats,
                        r_reg.lineOk, r_reg.st, r_reg.err};
      end
      else
      begin
        r_next.rdata = 32'h0000_0000;
      end
    end
    // Fill buffer hit: same one-cycle latency as a cache hit
    if (cpuReq && bufHit && !fwd)
    begin
      r_next.instrValid = 1'b1;
      r_next.instr = r_reg.line[cpuAddr[2:0]];
    end
    case (r_reg.st)
      ST_IDLE:
      begin
        if (missStart)
        begin
          // Buffer is reclaimed by the new line, dropping any old one
          r_next.st = ST_REQ;
          r_next.addr = cpuAddr;
          r_next.cach = cpuCacheable || cpuTouch;
          r_next.size8 = cpuCacheable || cpuTouch || r_reg.ncSize;
          r_next.user = cpuUserAttr;
          r_next.prio = r_reg.cfgPrio;
          r_next.touch = cpuTouch;
          r_next.want = !cpuTouch;
          r_next.vld = 8'h00;
          r_next.beats = 4'h0;
          r_next.lineOk = 1'b1;
        end
      end
      ST_REQ:
      begin
        if (slaveAddrAck)
        begin
          r_next.st = ST_DATA;
          r_next.w64 = slaveWidth64;
        end
        else if (abortReq)
        begin
          r_next.st = ST_IDLE;
          r_next.lineOk = 1'b0;
        end
      end
      ST_DATA:
      begin
        if (abortReq)
        begin
          // Acked fetch runs on, but its target is no longer wanted
          r_next.want = 1'b0;
        end
        if (slaveRdDataAck)
        begin
          r_next.beats = r_reg.beats + 4'h1;
          if (r_reg.w64)
          begin
            r_next.line[evenPos] = slaveRdData[63:32];
            r_next.line[evenPos | 3'h1] = slaveRdData[31:0];
            r_next.vld[evenPos] = 1'b1;
            r_next.vld[evenPos | 3'h1] = 1'b1;
          end
          else
          begin
            r_next.line[slaveRdWordPos] = slaveRdData[63:32];
            r_next.vld[slaveRdWordPos] = 1'b1;
          end
          if (fwd)
          begin
            r_next.instrValid = 1'b1;
            r_next.want = 1'b0;
            if (r_reg.w64 && r_reg.addr[0])
            begin
              r_next.instr = slaveRdData[31:0];
            end
            else
            begin
              r_next.instr = slaveRdData[63:32];
            end
          end
          if (slaveError)
          begin
            // Bad line must never reach the cache or serve a hit
            r_next.lineOk = 1'b0;
          end
          if (done)
          begin
            r_next.st = ST_IDLE;
            r_next.cacheWr = r_reg.cach && r_reg.lineOk && !slaveError
                             && (!r_reg.noAlloc || r_reg.touch);
          end
        end
      end
      default:
      begin
        r_next.st = ST_IDLE;
      end
    endcase
    // Set beats the software clear in the same cycle
    if (slaveError && r_reg.st != ST_IDLE)
    begin
      r_next.err = 1'b1;
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      r_reg <= '0;
      r_reg.st <= ST_IDLE;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // ==========================================
  // Outputs; no bus write strobe or byte enable exists, only the cache write enable
  assign fetchReq = r_reg.st == ST_REQ;
  assign fetchAddr = r_reg.addr;
  assign fetchXferSize = r_reg.size8 ? `IFBM_SIZE_8W : `IFBM_SIZE_4W;
  assign fetchCacheableAttr = r_reg.cach;
  assign fetchUserAttr = r_reg.user;
  assign fetchPriority = r_reg.prio;
  assign fetchAbort = r_reg.st == ST_REQ && abortReq && !slaveAddrAck;
  assign instrValid = r_reg.instrValid;
  assign instrData = r_reg.instr;
  assign cacheWrEn = r_reg.cacheWr;
  assign cacheWrLine = r_reg.addr[29:3];
  assign cacheWrData = r_reg.line;
  assign regRdata = r_reg.rdata;

  // ==========================================
  // Checks
  a_req_held_stable: assert property (@(posedge mclk) disable iff (rst)
    fetchReq && !slaveAddrAck && !fetchAbort |=> fetchReq && $stable(fetchAddr)
      && $stable(fetchXferSize) && $stable(fetchPriority))
    else $error("request changed before acknowledge");
  a_cacheable_eight: assert property (@(posedge mclk) disable iff (rst)
    fetchReq && fetchCacheableAttr |-> fetchXferSize == `IFBM_SIZE_8W)
    else $error("cacheable fetch not eight words");
  a_noncache_size: assert property (@(posedge mclk) disable iff (rst)
    missStart && !cpuCacheable && !cpuTouch |=> fetchXferSize
      == ($past(r_reg.ncSize) ? `IFBM_SIZE_8W : `IFBM_SIZE_4W))
    else $error("non-cacheable size ignores config");
  a_abort_unacked: assert property (@(posedge mclk) disable iff (rst)
    fetchAbort |-> fetchReq && !slaveAddrAck ##1 !fetchReq)
    else $error("abort of acknowledged or held request");
  a_miss_requests: assert property (@(posedge mclk) disable iff (rst)
    missStart |=> fetchReq && fetchAddr == $past(cpuAddr))
    else $error("miss did not raise request");
  a_buf_hit_fast: assert property (@(posedge mclk) disable iff (rst)
    cpuReq && bufHit && !fwd |=> instrValid
      && instrData == $past(r_reg.line[cpuAddr[2:0]]))
    else $error("buffer hit not one cycle");
  a_target_bypass: assert property (@(posedge mclk) disable iff (rst)
    fwd |=> instrValid)
    else $error("target word not forwarded");
  a_fill_to_cache: assert property (@(posedge mclk) disable iff (rst)
    done && r_reg.cach && r_reg.lineOk && !slaveError && !r_reg.noAlloc
      |=> cacheWrEn ##1 !cacheWrEn)
    else $error("full cacheable line not written");
  a_noncache_kept: assert property (@(posedge mclk) disable iff (rst)
    cacheWrEn |-> fetchCacheableAttr && r_reg.st == ST_IDLE)
    else $error("non-cacheable line written to cache");
  a_touch_allocates: assert property (@(posedge mclk) disable iff (rst)
    done && r_reg.touch && r_reg.lineOk && !slaveError |=> cacheWrEn)
    else $error("touch line not allocated");
endmodule // ifbm_fetch_master

`default_nettype wire

// >>> rtl/ifbm_pkg.sv
// Types of the instruction fetch bus master.
// Assumes nothing beyond a SystemVerilog compiler.
package ifbm_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_DATA} ifbm_state_t;

  typedef struct packed {
    ifbm_state_t      st;
    logic [29:0]      addr;
    logic             size8;
    logic             cach;
    logic             user;
    logic             touch;
    logic [1:0]       prio;
    logic             w64;
    logic             want;
    logic [3:0]       beats;
    logic [7:0]       vld;
    logic [7:0][31:0] line;
    logic             lineOk;
    logic             err;
    logic             ncSize;
    logic             noAlloc;
    logic [1:0]       cfgPrio;
    logic             instrValid;
    logic [31:0]      instr;
    logic             cacheWr;
    logic [31:0]      rdata;
  } ifbm_regs_t;
endpackage

// >>> tb/ifbm_bus_slave.sv
// Behavioural bus slave that answers the fetch master's line requests.
// Assumes the master's mclk; the bench picks width, pacing and errors.
`timescale 1ns/1ps
`default_nettype none
module ifbm_bus_slave (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        fetchReq,
  input  wire logic [29:0] fetchAddr,
  input  wire logic [1:0]  fetchXferSize,
  input  wire logic        fetchAbort,
  input  wire logic        w64,
  input  wire logic        slow,
  input  wire logic        errOn,
  output logic             slaveAddrAck,
  output logic             slaveWidth64,
  output logic             slaveRdDataAck,
  output logic [63:0]      slaveRdData,
  output logic [2:0]       slaveRdWordPos,
  output logic             slaveError,
  output logic             busy
);
  logic [29:0] a;
  logic [2:0]  base, p, m, off;
  logic [3:0]  cnt, k, n;
  function automatic logic [31:0] wv(input logic [2:0] q);
    return {2'h2, a[29:3], q};
  endfunction
  assign slaveWidth64 = w64;
  // =====================================
  // Address and data phases, one clock with the core
  always @(posedge mclk)
  begin
    slaveAddrAck <= 1'b0;
    slaveRdDataAck <= 1'b0;
    slaveError <= 1'b0;
    // Released lines flip so stale data never passes as valid
    slaveRdData <= ~slaveRdData;
    slaveRdWordPos <= ~slaveRdWordPos;
    if (rst)
    begin
      busy <= 1'b0;
      cnt <= 4'h0;
      slaveRdData <= 64'h0;
      slaveRdWordPos <= 3'h0;
    end
    else if (!busy)
    begin
      if (!fetchReq || fetchAbort)
        cnt <= 4'h0;
      else if (cnt != (slow ? 4'h6 : 4'h0))
        cnt <= cnt + 4'h1;
      else
      begin
        slaveAddrAck <= 1'b1;
        busy <= 1'b1;
        cnt <= 4'h0;
        k <= 4'h0;
        a <= fetchAddr;
        n <= (fetchXferSize == 2'h2 ? 4'h8 : 4'h4) >> w64;
        base <= fetchXferSize == 2'h2 ? 3'h0 : {fetchAddr[2], 2'h0};
      end
    end
    else if (cnt != (slow ? 4'h1 : 4'h0))
      cnt <= cnt + 4'h1;
    else
    begin
      m = n[2:0] - 3'h1;
      off = a[2:0] - base;
      // Target first, then wrap through the block
      p = base + (w64 ? (((off >> 1) + k[2:0]) & m) << 1 : (off + k[2:0]) & m);
      slaveRdDataAck <= 1'b1;
      slaveRdWordPos <= p;
      slaveRdData <= w64 ? {wv(p), wv(p | 3'h1)} : {wv(p), ~wv(p)};
      slaveError <= errOn && k == 4'h0;
      cnt <= 4'h0;
      k <= k + 4'h1;
      if (k == n - 4'h1)
        busy <= 1'b0;
    end
  end
endmodule // ifbm_bus_slave
`default_nettype wire

// >>> tb/tb_instruction_fetch_bus_master.sv
// Self-checking bench for the fetch master with a behavioural slave.
// Assumes ifbm_defs.svh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "ifbm_defs.svh"
module tb_instruction_fetch_bus_master;
  logic mclk, rst, cpuReq, cpuCacheable, cpuUserAttr, cpuTouch, cacheHit, abortReq;
  logic instrValid, cacheWrEn, regWr, regRd, fetchReq, fetchCacheableAttr, fetchUserAttr, fetchAbort;
  logic slaveAddrAck, slaveWidth64, slaveRdDataAck, slaveError, busy, w64, slow, errOn, rCach, rUser, pReq;
  logic [29:0]  cpuAddr, fetchAddr, rAddr, pAddr;
  logic [31:0]  instrData, regWdata, regRdata, gotR, gotI;
  logic [26:0]  cacheWrLine, wLine;
  logic [255:0] cacheWrData, wData;
  logic [3:0]   regAddr;
  logic [1:0]   fetchXferSize, fetchPriority, rSize, rPrio;
  logic [63:0]  slaveRdData;
  logic [2:0]   slaveRdWordPos;
  int failCount = 0, nCompared = 0, nReq = 0, nWr = 0, lat, w;
  ifbm_fetch_master DUT (.mclk, .rst, .cpuReq, .cpuAddr, .cpuCacheable, .cpuUserAttr, .cpuTouch, .cacheHit,
    .abortReq, .instrValid, .instrData, .cacheWrEn, .cacheWrLine, .cacheWrData, .regAddr, .regWdata, .regWr,
    .regRd, .regRdata, .fetchReq, .fetchAddr, .fetchXferSize, .fetchCacheableAttr, .fetchUserAttr,
    .fetchPriority, .fetchAbort, .slaveAddrAck, .slaveWidth64, .slaveRdDataAck, .slaveRdData,
    .slaveRdWordPos, .slaveError);
  ifbm_bus_slave slv (.mclk, .rst, .fetchReq, .fetchAddr, .fetchXferSize, .fetchAbort, .w64, .slow, .errOn,
    .slaveAddrAck, .slaveWidth64, .slaveRdDataAck, .slaveRdData, .slaveRdWordPos, .slaveError, .busy);
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // =====================================
  // Helpers
  task automatic chk(input logic [255:0] g, input logic [255:0] e);
    nCompared++;
    if (g !== e)
    begin
      failCount++;
      $display("unexpected at %0t: got %0h exp %0h", $time, g, e);
    end
  endtask
  task automatic printVerdict;
    $display("compared %0d, mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [255:0] expLine(input logic [26:0] l);
    logic [255:0] r;
    for (int i = 0; i < 8; i++)
      r[32*i +: 32] = {2'h2, l, 3'(i)};
    return r;
  endfunction
  task automatic regW(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic regR(input logic [3:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 gotR = regRdata;
  endtask
  // Core holds the access until served; the extra held cycle is a buffer hit
  task automatic acc(input logic [29:0] a, input logic c, input logic u, input logic t, input logic h);
    @(posedge mclk);
    {cpuReq, cpuAddr, cpuCacheable, cpuUserAttr, cpuTouch, cacheHit} <= {1'b1, a, c, u, t, h};
    lat = 0;
    do
    begin
      @(posedge mclk);
      #1 lat++;
    end while (instrValid !== 1'b1 && lat < 40);
    gotI = instrData;
    @(posedge mclk);
    {cpuReq, cpuTouch} <= 2'h0;
  endtask
  // A request raised just before the call is acknowledged at the next edge
  task automatic settle;
    w = 0;
    repeat (2) @(posedge mclk);
    while (busy !== 1'b0 && w < 100)
    begin
      @(posedge mclk);
      w++;
    end
    if (w == 100)
    begin
      failCount++;
      $display("unexpected at %0t: slave busy %0h exp %0h", $time, busy, 1'b0);
    end
    repeat (3) @(posedge mclk);
  endtask
  // =====================================
  // Bus monitor
  always @(posedge mclk)
  begin
    if (fetchReq === 1'b1 && pReq && slaveAddrAck !== 1'b1)
      chk(fetchAddr, pAddr);
    if (fetchReq === 1'b1 && slaveAddrAck === 1'b1)
    begin
      nReq++;
      {rAddr, rSize, rCach, rUser, rPrio} = {fetchAddr, fetchXferSize, fetchCacheableAttr, fetchUserAttr,
        fetchPriority};
    end
    if (cacheWrEn === 1'b1)
    begin
      nWr++;
      {wLine, wData} = {cacheWrLine, cacheWrData};
    end
    pReq = fetchReq === 1'b1;
    pAddr = fetchAddr;
  end
  initial
  begin
    #100000;
    failCount++;
    printVerdict();
  end
  // =====================================
  // Tests
  initial
  begin
    {cpuReq, cpuCacheable, cpuUserAttr, cpuTouch, cacheHit, abortReq, regWr, regRd, w64, slow, errOn} = '0;
    {cpuAddr, regAddr, regWdata} = '0;
    rst = 1'b1;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    #1 chk({fetchReq, fetchXferSize}, {1'b0, `IFBM_SIZE_4W});
    regW(4'hC, 32'hF);
    regR(`IFBM_CFG_ADDR);
    chk(gotR, `IFBM_CFG_RESET);
    regR(4'h8);
    chk(gotR, 32'h0);
    w64 <= 1'b1;
    regW(`IFBM_CFG_ADDR, 32'hC);
    acc(30'h1235, 1'b1, 1'b1, 1'b0, 1'b0);
    chk(gotI, {2'h2, 30'h1235});
    chk({rAddr, rSize}, {30'h1235, `IFBM_SIZE_8W});
    chk({rCach, rUser, rPrio}, 4'hF);
    settle();
    chk({nWr, wLine}, {32'd1, 27'h246});
    chk(wData, expLine(27'h246));
    acc(30'h1232, 1'b1, 1'b0, 1'b0, 1'b0);
    chk({lat, gotI, nReq}, {32'd1, 2'h2, 30'h1232, 32'd1});
    regW(`IFBM_CFG_ADDR, 32'h2);
    acc(30'h2001, 1'b1, 1'b0, 1'b0, 1'b0);
    settle();
    chk({gotI, nWr}, {2'h2, 30'h2001, 32'd1});
    @(posedge mclk);
    {cpuReq, cpuTouch, cpuAddr, cpuCacheable} <= {2'h3, 30'h3000, 1'b0};
    @(posedge mclk);
    {cpuReq, cpuTouch} <= 2'h0;
    settle();
    chk({nWr, wLine, rSize}, {32'd2, 27'h600, `IFBM_SIZE_8W});
    {w64, slow} <= 2'h1;
    regW(`IFBM_CFG_ADDR, 32'h0);
    acc(30'h4006, 1'b0, 1'b0, 1'b0, 1'b1);
    chk({gotI, rSize, rCach}, {2'h2, 30'h4006, `IFBM_SIZE_4W, 1'b0});
    settle();
    regR(`IFBM_STAT_ADDR);
    chk({nWr, gotR}, {32'd2, 32'h0000F048});
    acc(30'h4005, 1'b0, 1'b0, 1'b0, 1'b1);
    chk({lat, gotI, nReq}, {32'd1, 2'h2, 30'h4005, 32'd4});
    regW(`IFBM_CFG_ADDR, 32'h1);
    acc(30'h5003, 1'b0, 1'b0, 1'b0, 1'b0);
    chk({gotI, rSize}, {2'h2, 30'h5003, `IFBM_SIZE_8W});
    settle();
    slow <= 1'b0;
    acc(30'h6000, 1'b1, 1'b0, 1'b0, 1'b1);
    chk(nReq, 5);
    slow <= 1'b1;
    @(posedge mclk);
    {cpuReq, cpuAddr, cpuCacheable, cacheHit} <= {1'b1, 30'h7000, 2'h0};
    for (w = 0; fetchReq !== 1'b1 && w < 20; w++)
      @(posedge mclk);
    @(posedge mclk);
    {abortReq, cpuReq} <= 2'h2;
    #1 chk(fetchAbort, 1'b1);
    @(posedge mclk);
    abortReq <= 1'b0;
    #1 chk({fetchReq, fetchAbort, nReq}, {2'h0, 32'd5});
    {slow, errOn, w64} <= 3'h3;
    acc(30'h8001, 1'b1, 1'b0, 1'b0, 1'b0);
    settle();
    regR(`IFBM_STAT_ADDR);
    chk({nWr, gotR[0]}, {32'd2, 1'b1});
    errOn <= 1'b0;
    regW(`IFBM_STAT_ADDR, 32'h1);
    regR(`IFBM_STAT_ADDR);
    chk(gotR[0], 1'b0);
    printVerdict();
  end
endmodule // tb_instruction_fetch_bus_master
`default_nettype wire
